// *** rtl/dram_ctl_regs.svh ***
// Purpose: Constants for the DRAM init, address mux and refresh block
// Assumes: Included by its bare name from the design and the bench
// Notes:   Offsets are absent; configuration arrives on plain ports
`ifndef DRAM_CTL_REGS_SVH
`define DRAM_CTL_REGS_SVH

// =====================================================================
// Command words
`define CMD_PRECHARGE     32'h00000004
`define CMD_CBR_REFRESH   32'h00000005

// =====================================================================
// Column length encodings and split base
`define COL_LEN_8         2'h0
`define COL_LEN_9         2'h1
`define COL_LEN_10        2'h2
`define COL_SPLIT_BASE    5'h08

// =====================================================================
// Reset values
`define IDLE_COUNT_RST    4'h3
`define BUS_WIDTH_RST     2'h0

// =====================================================================
// Timing: power-up settle time kept by software, in microseconds
`define INIT_WAIT_US      200
`define CLK_MHZ           125
`define INIT_WAIT_CYC     (`INIT_WAIT_US * `CLK_MHZ)

`endif

// *** rtl/dram_ctl_pkg.sv ***
// Purpose: Types for the DRAM init, address mux and refresh block
// Assumes: Constants come from dram_ctl_regs.svh
// Notes:   States are one-hot
package dram_ctl_pkg;

    // =================================================================
    // Controller states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACT  = 5'b00010,
        ST_COL  = 5'b00100,
        ST_PRE  = 5'b01000,
        ST_REF  = 5'b10000
    } state_t;

    // =================================================================
    // DRAM command pins, all active low
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dram_cmd_t;

    // =================================================================
    // Software configuration image
    typedef struct packed {
        logic [1:0] bus_width;
        logic       width16;
        logic [2:0] timing;
        logic       sdram;
        logic [1:0] col_len;
        logic       auto_refresh;
        logic       pd_enable;
        logic [3:0] idle_count;
        logic [7:0] ref_period_a;
        logic [7:0] ref_period_b;
    } dram_cfg_t;

endpackage : dram_ctl_pkg

// *** rtl/dram_ctl.sv ***
// Purpose: DRAM controller core: init commands, row/column mux, refresh, power-down
// Assumes: Single clock, synchronous active-high reset, software follows init order
// Notes:   Auto-precharge is never used; every access ends with precharge-all
`timescale 1ns/100ps
`include "dram_ctl_regs.svh"

// Overview of operation
// - Disabled strap stops the controller and ignores all configuration and command writes.
// - Command word 0x00000004 issues a precharge of all banks.
// - Each command word 0x00000005 queues one CBR refresh, pending count saturating at 15; init writes eight.
// - Column-length codes 00, 01, 10 split host address at 8, 9, 10 bits.
// - Row phase carries host bit k plus column length; unused upper outputs are 0.
// - Column lengths of 11 or more bits are not supported.
// - Width bit picks 16-bit or 8-bit bus; the pin mapping is the same for both.
// - SDRAM may only run on the 16-bit bus width.
// - For EDO, column-phase address bit 11 carries host bit 11.
// - For SDRAM, address bit 11 is 0 on READ/WRITE: no auto-precharge.
// - For SDRAM, address bits 18 to 12 hold the bank in both phases.
// - Distributed CBR refresh is issued at intervals set by two period registers.
// - Automatic refresh runs while the auto-refresh bit is set, stops when cleared.
// - A refresh command word refreshes once whenever the strap is enabled, auto refresh or not.
// - Idle count field plus one gives 1 to 16 idle cycles before power-down.
// - On SDRAM, clock enable drops when enabled, idle long enough, no requests; rises on any.
module dram_ctl
    import dram_ctl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        memctl_enable_strap_n_in,
    input  wire logic        cfg_wr_in,
    input  wire dram_cfg_t   cfg_in,
    input  wire logic        cmd_wr_in,
    input  wire logic [31:0] cmd_data_in,
    input  wire logic        host_req_in,
    input  wire logic        host_write_in,
    input  wire logic [26:0] host_address_in,
    output logic             host_ack_out,
    output logic [23:0]      external_address_out,
    output dram_cmd_t        dram_cmd_out,
    output logic             cke_out,
    output logic             ctl_on_out
);

    // =================================================================
    // Command encodings
    localparam dram_cmd_t CMD_NOP  = 4'b0111;
    localparam dram_cmd_t CMD_ACT  = 4'b0011;
    localparam dram_cmd_t CMD_RD   = 4'b0101;
    localparam dram_cmd_t CMD_WR   = 4'b0100;
    localparam dram_cmd_t CMD_PALL = 4'b0010;
    localparam dram_cmd_t CMD_REFH = 4'b0001;

    function automatic logic cmd_is(input logic [31:0] data, input logic [31:0] code);
        cmd_is = (data == code);
    endfunction : cmd_is

    // =================================================================
    // State
    logic        strap_meta_ff, strap_n_ff;
    dram_cfg_t   cfg_ff;
    state_t      state_ff, nxt_state;
    logic [2:0]  wait_ff;
    logic [3:0]  ref_cnt_ff;
    logic        pre_pend_ff;
    logic [7:0]  pre_div_ff, per_cnt_ff;
    logic [4:0]  idle_cnt_ff;
    logic        acc_write_ff;
    logic [23:0] nxt_addr;
    dram_cmd_t   nxt_cmd;

    // =================================================================
    // Strap pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strap_meta_ff <= 1'b1;
            strap_n_ff    <= 1'b1;
        end else if (ce_in) begin
            strap_meta_ff <= memctl_enable_strap_n_in;
            strap_n_ff    <= strap_meta_ff;
        end
    end

    wire strap_on = ~strap_n_ff;
    wire cfg_take = strap_on & cfg_wr_in;
    wire cmd_take = strap_on & cmd_wr_in;
    wire cmd_pre  = cmd_take & cmd_is(cmd_data_in, `CMD_PRECHARGE);
    wire cmd_ref  = cmd_take & cmd_is(cmd_data_in, `CMD_CBR_REFRESH);

    // Column code 11 leaves memory unusable
    wire col_ok = (cfg_ff.col_len != 2'h3);
    // SDRAM on the 8-bit bus is refused
    wire width_ok = cfg_ff.width16 | ~cfg_ff.sdram;
    // Nonzero width enables access; width bit only gates SDRAM
    wire ctl_on = strap_on & (cfg_ff.bus_width != `BUS_WIDTH_RST) & col_ok & width_ok;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_ff            <= '0;
            cfg_ff.idle_count <= `IDLE_COUNT_RST;
        end else if (ce_in && cfg_take) begin
            cfg_ff <= cfg_in;
        end
    end

    // =================================================================
    // Address multiplexing
    // Split point is base plus column code
    wire [4:0]  col_bits = `COL_SPLIT_BASE + {3'h0, cfg_ff.col_len};
    wire [31:0] host_ext = {5'h00, host_address_in};
    // Row half shifted down; bits past host bit 26 fill with 0
    wire [31:0] row_sh   = host_ext >> col_bits;
    wire [23:0] row_addr = row_sh[23:0];
    // EDO carries host bit 11; SDRAM forces 0
    wire        col_a11  = cfg_ff.sdram ? 1'b0 : host_address_in[11];
    // Bank bits repeat the row value in the column phase
    wire [23:0] col_addr = {5'h00, row_addr[18:12], col_a11, host_address_in[10:0]};

    // =================================================================
    // Distributed refresh timer
    // Interval is (a+1)*(b+1) cycles
    wire pre_wrap = (pre_div_ff == 8'h00);
    wire ref_tick = cfg_ff.auto_refresh & ctl_on & pre_wrap & (per_cnt_ff == 8'h00);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_div_ff <= 8'h00;
            per_cnt_ff <= 8'h00;
        // Timer reloaded from both period fields while auto refresh is off
        end else if (ce_in && !(cfg_ff.auto_refresh && ctl_on)) begin
            pre_div_ff <= cfg_ff.ref_period_a;
            per_cnt_ff <= cfg_ff.ref_period_b;
        end else if (ce_in) begin
            pre_div_ff <= pre_wrap ? cfg_ff.ref_period_a : pre_div_ff - 8'h01;
            if (pre_wrap) begin
                per_cnt_ff <= (per_cnt_ff == 8'h00) ? cfg_ff.ref_period_b : per_cnt_ff - 8'h01;
            end
        end
    end

    // =================================================================
    // Pending commands; a new request wins over the clear
    wire ref_start = (state_ff == ST_IDLE) && (nxt_state == ST_REF);
    wire pre_start = (state_ff == ST_IDLE) && (nxt_state == ST_PRE);
    // Each write or tick counts one refresh
    wire [1:0] ref_add = {1'b0, cmd_ref} + {1'b0, ref_tick};
    wire [3:0] ref_sum = ref_cnt_ff + {2'h0, ref_add} - {3'h0, ref_start};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ref_cnt_ff  <= 4'h0;
            pre_pend_ff <= 1'b0;
        end else if (ce_in) begin
            ref_cnt_ff  <= (ref_cnt_ff >= 4'he && ref_add != 2'h0) ? 4'hf : ref_sum;
            pre_pend_ff <= cmd_pre | (pre_pend_ff & ~pre_start);
        end
    end

    // =================================================================
    // Access sequencer
    wire wait_done = (wait_ff == 3'h0);
    wire can_go    = ctl_on & cke_out;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // Refresh first, then precharge, then host
                if (!can_go)
                    nxt_state = ST_IDLE;
                else if (ref_cnt_ff != 4'h0)
                    nxt_state = ST_REF;
                else if (pre_pend_ff)
                    nxt_state = ST_PRE;
                else if (host_req_in)
                    nxt_state = ST_ACT;
            end
            ST_ACT:  if (wait_done) nxt_state = ST_COL;
            ST_COL:  if (wait_done) nxt_state = ST_PRE;
            ST_PRE:  if (wait_done) nxt_state = ST_IDLE;
            ST_REF:  if (wait_done) nxt_state = ST_IDLE;
        endcase
        // No operation with the strap off
        if (!strap_on)
            nxt_state = ST_IDLE;
    end

    wire entering = (nxt_state != state_ff) && (nxt_state != ST_IDLE);
    wire acc_wr   = (state_ff == ST_IDLE) ? host_write_in : acc_write_ff;

    always_comb begin
        nxt_cmd  = CMD_NOP;
        nxt_addr = external_address_out;
        if (entering) begin
            unique case (nxt_state)
                ST_ACT: begin
                    nxt_cmd  = CMD_ACT;
                    nxt_addr = row_addr;
                end
                ST_COL: begin
                    nxt_cmd  = acc_wr ? CMD_WR : CMD_RD;
                    nxt_addr = col_addr;
                end
                ST_PRE: nxt_cmd = CMD_PALL;
                ST_REF: nxt_cmd = CMD_REFH;
                default: nxt_cmd = CMD_NOP;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff             <= ST_IDLE;
            wait_ff              <= 3'h0;
            acc_write_ff         <= 1'b0;
            dram_cmd_out         <= CMD_NOP;
            external_address_out <= 24'h000000;
            host_ack_out         <= 1'b0;
        end else if (ce_in) begin
            state_ff             <= nxt_state;
            wait_ff              <= entering ? cfg_ff.timing : (wait_done ? 3'h0 : wait_ff - 3'h1);
            acc_write_ff         <= acc_wr;
            dram_cmd_out         <= nxt_cmd;
            external_address_out <= nxt_addr;
            host_ack_out         <= entering && (nxt_state == ST_COL);
        end
    end

    // =================================================================
    // Power-down
    // Idle threshold is field plus one
    wire [4:0] idle_need = {1'b0, cfg_ff.idle_count} + 5'h01;
    wire       quiet     = (state_ff == ST_IDLE) & ~host_req_in & ~cfg_wr_in & ~cmd_wr_in
                           & (ref_cnt_ff == 4'h0) & ~pre_pend_ff & ~ref_tick;
    // Clock enable low only while quiet and idle long enough
    wire       pd_go     = cfg_ff.pd_enable & cfg_ff.sdram & ctl_on & quiet & (idle_cnt_ff >= idle_need);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            idle_cnt_ff <= 5'h00;
            cke_out     <= 1'b1;
            ctl_on_out  <= 1'b0;
        end else if (ce_in) begin
            idle_cnt_ff <= !quiet ? 5'h00 : (idle_cnt_ff == 5'h10 ? idle_cnt_ff : idle_cnt_ff + 5'h01);
            cke_out     <= ~pd_go;
            ctl_on_out  <= ctl_on;
        end
    end

    // =================================================================
    // Checks
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_strap_stops_fsm: assert property ((ce_in && !strap_on) |=> state_ff == ST_IDLE)
        else $error("controller runs with strap disabled");
    a_precharge_issued: assert property ((ce_in && entering && nxt_state == ST_PRE) |=> dram_cmd_out == CMD_PALL)
        else $error("precharge state without precharge command");
    a_refresh_counted: assert property (
        (ce_in && cmd_ref && !ref_tick && !ref_start && ref_cnt_ff < 4'he)
        |=> ref_cnt_ff == $past(ref_cnt_ff) + 4'h1)
        else $error("refresh command not counted");
    a_row_upper_zero: assert property ((dram_cmd_out == CMD_ACT) |-> external_address_out[23:19] == 5'h00)
        else $error("row address upper bits not zero");
    a_no_autoprecharge: assert property (
        (cfg_ff.sdram && (dram_cmd_out == CMD_RD || dram_cmd_out == CMD_WR))
        |-> !external_address_out[11])
        else $error("auto-precharge bit set on SDRAM column");
    a_bank_bits_held: assert property (
        (dram_cmd_out == CMD_RD || dram_cmd_out == CMD_WR)
        |-> external_address_out[18:12] == $past(external_address_out[18:12]))
        else $error("bank bits differ between row and column");
    a_auto_ref_off: assert property ((!cfg_ff.auto_refresh && !cmd_ref) |=> ref_cnt_ff <= $past(ref_cnt_ff))
        else $error("refresh queued while auto refresh is off");
    a_cke_wakes_up: assert property ((ce_in && host_req_in) |=> cke_out)
        else $error("clock enable low with host request");
    a_idle_before_pd: assert property ((ce_in && cke_out && pd_go) |-> idle_cnt_ff > {1'b0, cfg_ff.idle_count})
        else $error("power-down entered too early");
    a_refresh_first: assert property (
        (ce_in && state_ff == ST_IDLE && can_go && ref_cnt_ff != 4'h0 && host_req_in && strap_on)
        |=> state_ff == ST_REF)
        else $error("host access served before pending refresh");

    // Mapping checked against host bits directly, not through the shifter
    a_row_split_eight: assert property (
        (ce_in && entering && nxt_state == ST_ACT && cfg_ff.col_len == `COL_LEN_8)
        |=> external_address_out == {5'h00, $past(host_address_in[26:8])})
        else $error("row address not split at eight column bits");
    a_edo_col_bit: assert property (
        (ce_in && entering && nxt_state == ST_COL && !cfg_ff.sdram)
        |=> external_address_out[11] == $past(host_address_in[11]))
        else $error("EDO column bit 11 lost");
    a_sdram_narrow_off: assert property ((ce_in && cfg_ff.sdram && !cfg_ff.width16) |=> !ctl_on_out)
        else $error("SDRAM enabled on the 8-bit bus");
    a_pd_only_quiet: assert property ((ce_in && !quiet) |=> cke_out)
        else $error("clock enable low while requests are present");

endmodule : dram_ctl

// *** dv/dram_device_model.sv ***
// Purpose: Far-side memory model, decodes the command pins into events
// Assumes: Commands stand one cycle on registered pins
// Notes:   No data path; the bench compares the decoded events
`timescale 1ns/100ps
module dram_device_model
    import dram_ctl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire dram_cmd_t   dram_cmd_in,
    input  wire logic        cke_in,
    input  wire logic [23:0] external_address_in,
    output logic             evt_valid_out,
    output logic [3:0]       evt_cmd_out,
    output logic [23:0]      evt_addr_out
);
    // PALL, REFH, access decode
    // Pins wire straight to memory, 16-bit shift is board wiring only
    assign evt_cmd_out   = dram_cmd_in;
    assign evt_addr_out  = external_address_in;
    assign evt_valid_out = !rst_in && cke_in && (evt_cmd_out != 4'h7);
endmodule : dram_device_model

// *** dv/test_dram_ctl.sv ***
// Purpose: Self-checking bench for the DRAM init, mux and refresh core
// Assumes: Commands on the pins appear in the order they were requested
// Notes:   Expected commands are queued by the drivers, popped by the monitor
`timescale 1ns/100ps
`include "dram_ctl_regs.svh"
module test_dram_ctl
    import dram_ctl_pkg::*;
;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [23:0] addr;
        logic        use_addr;
    } note_t;
    localparam logic [3:0] ACT_C = 4'h3, RD_C = 4'h5, WR_C = 4'h4, PALL_C = 4'h2, REFH_C = 4'h1;
    logic        clk_in = 0, rst_in = 1, ce_in = 1, strap_n = 1, cfg_wr_in = 0, cmd_wr_in = 0;
    logic        host_req_in = 0, host_write_in = 0, host_ack_out, cke_out, ctl_on_out;
    logic        evt_valid, free_run = 0;
    logic [3:0]  evt_cmd;
    logic [23:0] evt_addr, external_address_out;
    logic [26:0] host_address_in = '0;
    logic [31:0] cmd_data_in = '0, rng = 32'h29;
    dram_cfg_t   cfg_in = '0, c;
    dram_cmd_t   dram_cmd_out;
    note_t       exp_q[$];
    int          error_cnt = 0, compares = 0, ref_seen = 0, snap;
    dram_ctl dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .memctl_enable_strap_n_in(strap_n),
        .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .cmd_wr_in(cmd_wr_in), .cmd_data_in(cmd_data_in),
        .host_req_in(host_req_in), .host_write_in(host_write_in), .host_address_in(host_address_in),
        .host_ack_out(host_ack_out), .external_address_out(external_address_out),
        .dram_cmd_out(dram_cmd_out), .cke_out(cke_out), .ctl_on_out(ctl_on_out));
    dram_device_model mem (.clk_in(clk_in), .rst_in(rst_in), .dram_cmd_in(dram_cmd_out), .cke_in(cke_out),
        .external_address_in(external_address_out), .evt_valid_out(evt_valid), .evt_cmd_out(evt_cmd),
        .evt_addr_out(evt_addr));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // =================================================================
    // Helpers
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic push(input logic [3:0] cmd, input logic [23:0] addr, input logic use_addr);
        note_t n;
        n = '{cmd: cmd, addr: addr, use_addr: use_addr};
        exp_q.push_back(n);
    endtask : push
    task automatic cfg_write(input dram_cfg_t v);
        @(posedge clk_in);
        cfg_in    <= v;
        cfg_wr_in <= 1'b1;
        @(posedge clk_in);
        cfg_wr_in <= 1'b0;
    endtask : cfg_write
    task automatic cmd_write(input logic [31:0] w);
        @(posedge clk_in);
        cmd_data_in <= w;
        cmd_wr_in   <= 1'b1;
        @(posedge clk_in);
        cmd_wr_in   <= 1'b0;
    endtask : cmd_write
    task automatic drain();
        int k;
        for (k = 0; k < 200 && exp_q.size() != 0; k++) @(posedge clk_in);
        if (exp_q.size() != 0) begin
            check("pending_cmds", exp_q.size(), 0);
            end_sim();
        end
    endtask : drain
    // Row split at 8 + column length; column keeps bank bits, and a11 for EDO only
    task automatic host_access(input logic [26:0] a, input logic wr);
        logic [26:0] sh;
        logic [23:0] row;
        int k;
        sh  = a >> (5'h08 + c.col_len);
        row = sh[23:0];
        push(ACT_C, row, 1'b1);
        push(wr ? WR_C : RD_C, {5'h00, row[18:12], c.sdram ? 1'b0 : a[11], a[10:0]}, 1'b1);
        push(PALL_C, '0, 1'b0);
        @(posedge clk_in);
        host_req_in     <= 1'b1;
        host_address_in <= a;
        host_write_in   <= wr;
        for (k = 0; k < 60 && host_ack_out !== 1'b1; k++) @(posedge clk_in);
        host_req_in <= 1'b0;
        if (k == 60) begin
            check("host_ack", 0, 1);
            end_sim();
        end
        drain();
    endtask : host_access
    // =================================================================
    // Monitor
    // Sampled mid-cycle so the registered pins have settled
    always @(negedge clk_in) begin
        note_t n;
        if (evt_valid === 1'b1) begin
            if (free_run) begin
                ref_seen += (evt_cmd == REFH_C);
            end else if (exp_q.size() == 0) begin
                check("unexpected_cmd", evt_cmd, 4'h7);
            end else begin
                n = exp_q.pop_front();
                check("dram_cmd", evt_cmd, n.cmd);
                if (n.use_addr) check("ext_addr", evt_addr, n.addr);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        check("watchdog", 0, 1);
        end_sim();
    end
    // =================================================================
    // Main sequence
    initial begin
        int m;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        tick(`INIT_WAIT_CYC);
        c = '{bus_width: 2'h1, width16: 1'b1, timing: 3'(rnd()), sdram: 1'b1, col_len: 2'h0,
              auto_refresh: 1'b0, pd_enable: 1'b0, idle_count: 4'h3, ref_period_a: 8'h03, ref_period_b: 8'h03};
        cfg_write(c);
        cmd_write(32'h00000005);
        tick(5);
        check("ctl_on_strap_off", ctl_on_out, 0);
        strap_n <= 1'b0;
        tick(5);
        check("ctl_on_cfg_refused", ctl_on_out, 0);
        cfg_write(c);
        tick(3);
        check("ctl_on_enabled", ctl_on_out, 1);
        push(PALL_C, '0, 1'b0);
        cmd_write(32'h00000004);
        for (m = 0; m < 8; m++) push(REFH_C, '0, 1'b0);
        for (m = 0; m < 8; m++) cmd_write(32'h00000005);
        cmd_write(32'h00000006);
        drain();
        for (m = 0; m < 6; m++) begin
            c.sdram   = m[0];
            c.col_len = m[2:1];
            cfg_write(c);
            tick(3);
            check("ctl_on_mode", ctl_on_out, 1);
            host_access(27'(rnd()), 1'b0);
            host_access(27'(rnd()), 1'b1);
        end
        c.col_len = 2'h3;
        cfg_write(c);
        tick(3);
        check("ctl_on_col11", ctl_on_out, 0);
        c = '{bus_width: 2'h1, width16: 1'b0, sdram: 1'b1, ref_period_a: 8'h03, ref_period_b: 8'h03, default: '0};
        cfg_write(c);
        tick(3);
        check("ctl_on_sdram8", ctl_on_out, 0);
        c.width16      = 1'b1;
        c.auto_refresh = 1'b1;
        free_run       = 1'b1;
        cfg_write(c);
        tick(160);
        check("auto_ref_count", ref_seen >= 9 && ref_seen <= 11, 1);
        c.auto_refresh = 1'b0;
        cfg_write(c);
        tick(6);
        snap = ref_seen;
        tick(100);
        check("auto_ref_stopped", ref_seen, snap);
        cmd_write(32'h00000005);
        tick(8);
        check("manual_ref", ref_seen, snap + 1);
        free_run = 1'b0;
        for (m = 0; m < 2; m++) begin
            c.pd_enable  = 1'b1;
            c.idle_count = m ? 4'hf : 4'h0;
            cfg_write(c);
            tick(c.idle_count + 1);
            check("cke_still_up", cke_out, 1);
            tick(1);
            check("cke_down", cke_out, 0);
            host_access(27'(rnd()), m[0]);
            check("cke_woke", cke_out, 1);
        end
        end_sim();
    end
endmodule : test_dram_ctl
